// file: verilog/fmsd_core.sv
// Speed pulse, direction reversal, lock protection and carrier timing for the fan motor driver.
//
// Operation
// - One high, one low per electrical revolution.
// - Speed pulses start after back-EMF under drive.
// - Speed pulse freezes when drive stops.
// - Transitions placed 90 degrees after U commutation.
// - Speed pulse pin is open drain.
// - Half rate only when select at middle.
// - Direction change brakes then restarts reversed.
// - Floating direction input reads high.
// - Sequencer intervals derive from the capacitor timebase; carrier and pulse delay count core cycles.
// - Output off for lock interval before restart.
// - Carrier switches at about 40 kHz.
// - Limit reduces duty, hard overcurrent locks.
// - Lock stops motor, retries start after interval.
`timescale 1ns/1ps
module fmsd_core
  import fmsd_pkg::*;
#(
  parameter int unsigned LOCK_TICKS = LOCK_OFF_TICKS,
  parameter int unsigned ALIGN_T = ALIGN_TICKS,
  parameter int unsigned START_T = START_TIMEOUT_TICKS,
  parameter int unsigned BRAKE_T = BRAKE_TICKS
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Asynchronous pins and comparator levels.
  input wire logic timebase_capacitor,
  input wire logic direction_select,
  input wire logic sel_mid_level,
  input wire logic zero_cross,
  input wire logic current_limit_in,
  input wire logic hard_overcurrent,
  // Same-clock inputs from the commutation engine and speed command decoder.
  input wire logic run_request,
  input wire logic u_commutate,
  // Output stage control.
  output logic drive_enable,
  output logic brake_active,
  output logic rotate_reverse,
  output logic duty_reduce,
  output logic pwm_carrier,
  output logic lock_active,
  // Open-drain speed pulse pin.
  output logic speed_pulse_out_o,
  output logic speed_pulse_out_oe
);

  // Two-stage synchronisers for all pins; stage one feeds stage two only.
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic tb_prev_reg;
  logic zc_prev_reg;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      // The direction pin has a pull-up, so it resets to high as if floating.
      sync1_reg <= 6'h01;
      sync2_reg <= 6'h01;
      tb_prev_reg <= 1'b0;
      zc_prev_reg <= 1'b0;
    end
    else
    begin
      // Bit order must match the named views below: 5 overcurrent, 4 zero cross, 3 limit, 2 timebase, 1 select.
      sync1_reg <= {hard_overcurrent, zero_cross, current_limit_in, timebase_capacitor, sel_mid_level,
                    direction_select};
      sync2_reg <= sync1_reg;
      tb_prev_reg <= sync2_reg[2];
      zc_prev_reg <= sync2_reg[4];
    end
  end

  // Named views of the synchronised levels.
  logic dir_s;
  logic sel_mid_s;
  logic limit_s;
  logic hard_overcurrent_s;
  logic tb_tick;
  logic zc_edge;
  assign dir_s = sync2_reg[0];
  assign sel_mid_s = sync2_reg[1];
  assign limit_s = sync2_reg[3];
  assign hard_overcurrent_s = sync2_reg[5];
  // One timebase tick per rising edge of the capacitor oscillator.
  assign tb_tick = sync2_reg[2] & ~tb_prev_reg;
  // Any back-EMF zero crossing edge counts as detection.
  assign zc_edge = sync2_reg[4] ^ zc_prev_reg;

  // Sequencer state and the timebase interval counter.
  fmsd_state_t state_reg;
  fmsd_state_t state_next;
  logic [TICK_W-1:0] tick_reg;
  logic [TICK_W-1:0] tick_next;
  logic dir_reg;
  logic dir_next;

  // Decides whether the interval counter has reached a given tick count.
  function automatic logic ticks_done(input logic [TICK_W-1:0] cnt, input int unsigned lim);
    ticks_done = (cnt >= TICK_W'(lim - 1));
  endfunction : ticks_done

  // Next-state logic of the motor sequencer.
  always_comb
  begin
    state_next = state_reg;
    tick_next = tb_tick ? tick_reg + TICK_W'(1) : tick_reg;
    dir_next = dir_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        // Latch the direction only while stopped, so a change later is seen as a reversal.
        dir_next = dir_s;
        tick_next = '0;
        if (run_request)
          state_next = ST_ALIGN;
      end
      ST_ALIGN:
      begin
        if (tb_tick && ticks_done(tick_reg, ALIGN_T))
        begin
          state_next = ST_START;
          tick_next = '0;
        end
      end
      ST_START:
      begin
        // Failing to find a back-EMF zero crossing edge in time is a locked rotor.
        if (zc_edge)
          state_next = ST_RUN;
        else if (tb_tick && ticks_done(tick_reg, START_T))
        begin
          state_next = ST_LOCK;
          tick_next = '0;
        end
      end
      ST_RUN:
      begin
        tick_next = '0;
        if (!run_request)
          state_next = ST_IDLE;
      end
      ST_BRAKE:
      begin
        // Brake for a fixed span, then start over in the new direction.
        if (tb_tick && ticks_done(tick_reg, BRAKE_T))
        begin
          state_next = ST_ALIGN;
          tick_next = '0;
          dir_next = dir_s;
        end
      end
      ST_LOCK:
      begin
        // The output stays off for the whole interval before a retry.
        if (tb_tick && ticks_done(tick_reg, LOCK_TICKS))
        begin
          state_next = run_request ? ST_ALIGN : ST_IDLE;
          tick_next = '0;
        end
      end
    endcase
    // Hard overcurrent wins over everything while the stage drives.
    if (hard_overcurrent_s && (state_reg inside {ST_ALIGN, ST_START, ST_RUN}))
    begin
      state_next = ST_LOCK;
      tick_next = '0;
    end
    else if ((dir_s != dir_reg) && (state_reg inside {ST_ALIGN, ST_START, ST_RUN}))
    begin
      state_next = ST_BRAKE;
      tick_next = '0;
    end
  end

  // Registers of the sequencer.
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_IDLE;
      tick_reg <= '0;
      dir_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      tick_reg <= tick_next;
      dir_reg <= dir_next;
    end
  end

  // Drive is on in alignment, start and run.
  logic driving;
  assign driving = state_next inside {ST_ALIGN, ST_START, ST_RUN};

  // Carrier divider and output stage control.
  logic [15:0] car_cnt_reg;
  logic [15:0] car_cnt_next;
  logic car_reg;
  logic car_next;
  always_comb
  begin
    car_cnt_next = car_cnt_reg + 16'h0001;
    car_next = car_reg;
    // The carrier half period is a whole count of core cycles.
    if (car_cnt_reg == 16'(PWM_HALF_CYCLES - 1))
    begin
      car_cnt_next = 16'h0000;
      car_next = ~car_reg;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      car_cnt_reg <= 16'h0000;
      car_reg <= 1'b0;
      drive_enable <= 1'b0;
      brake_active <= 1'b0;
      rotate_reverse <= 1'b0;
      duty_reduce <= 1'b0;
      pwm_carrier <= 1'b0;
      lock_active <= 1'b0;
    end
    else
    begin
      car_cnt_reg <= car_cnt_next;
      car_reg <= car_next;
      drive_enable <= driving;
      brake_active <= (state_next == ST_BRAKE);
      rotate_reverse <= ~dir_next;
      // Soft limit trims duty only while running.
      duty_reduce <= limit_s && (state_next == ST_RUN);
      pwm_carrier <= car_next & driving;
      lock_active <= (state_next == ST_LOCK);
    end
  end

  // Speed pulse timing: measure the U commutation spacing and toggle a quarter revolution later.
  logic [PER_W-1:0] per_cnt_reg;
  logic [PER_W-1:0] per_cnt_next;
  logic [PER_W-1:0] delay_reg;
  logic [PER_W-1:0] delay_next;
  logic pend_reg;
  logic pend_next;
  logic armed_reg;
  logic armed_next;
  logic half_reg;
  logic half_next;
  logic fg_reg;
  logic fg_next;
  always_comb
  begin
    per_cnt_next = per_cnt_reg + PER_W'(1);
    delay_next = delay_reg;
    pend_next = pend_reg;
    armed_next = armed_reg;
    half_next = half_reg;
    fg_next = fg_reg;
    // Pulses are armed by back-EMF under drive and disarmed when drive stops.
    if (!driving)
    begin
      armed_next = 1'b0;
      pend_next = 1'b0;
    end
    else if (zc_edge)
      armed_next = 1'b1;
    // U commutation points come twice per revolution; half their spacing is 90 degrees.
    if (u_commutate)
    begin
      per_cnt_next = '0;
      delay_next = {1'b0, per_cnt_reg[PER_W-1:1]};
      pend_next = driving && armed_reg;
    end
    else if (pend_reg && driving)
    begin
      // A toggle that falls due in the cycle drive stops is dropped, so the pin freezes at once.
      if (delay_reg == '0)
      begin
        pend_next = 1'b0;
        // Two toggles per revolution give one high and one low.
        half_next = ~half_reg;
        if (!sel_mid_s || !half_reg)
          fg_next = ~fg_reg;
      end
      else
        delay_next = delay_reg - PER_W'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      per_cnt_reg <= '0;
      delay_reg <= '0;
      pend_reg <= 1'b0;
      armed_reg <= 1'b0;
      half_reg <= 1'b0;
      fg_reg <= 1'b1;
      speed_pulse_out_o <= 1'b0;
      speed_pulse_out_oe <= 1'b0;
    end
    else
    begin
      per_cnt_reg <= per_cnt_next;
      delay_reg <= delay_next;
      pend_reg <= pend_next;
      armed_reg <= armed_next;
      half_reg <= half_next;
      fg_reg <= fg_next;
      // The pin only ever pulls low; the external pull-up makes the high.
      speed_pulse_out_o <= 1'b0;
      speed_pulse_out_oe <= ~fg_next;
    end
  end

  // Checks on the sequencer and the speed pulse.
  sequence s_lock_expire;
    state_reg == ST_LOCK && tb_tick && ticks_done(tick_reg, LOCK_TICKS);
  endsequence

  AST_OPEN_DRAIN: assert property (@(posedge core_clk) disable iff (sys_rst)
    speed_pulse_out_o == 1'b0) else $error("Speed pulse pin drove high.");
  AST_NO_PULSE_UNDRIVEN: assert property (@(posedge core_clk) disable iff (sys_rst)
    !drive_enable && !driving |=> $stable(speed_pulse_out_oe)) else $error("Speed pulse moved without drive.");
  AST_ARM_NEEDS_ZC: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(armed_reg) |-> $past(zc_edge)) else $error("Speed pulse armed without back-EMF.");
  AST_LOCK_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
    lock_active |-> !drive_enable && !pwm_carrier) else $error("Output stage on during lock.");
  AST_OCP_LOCK: assert property (@(posedge core_clk) disable iff (sys_rst)
    hard_overcurrent_s && state_reg == ST_RUN |=> lock_active) else $error("Hard overcurrent did not lock.");
  AST_RETRY: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_lock_expire ##0 run_request |=> state_reg == ST_ALIGN && drive_enable) else $error("No retry after lock.");
  AST_REVERSE_BRAKE: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_reg == ST_RUN && dir_s != dir_reg && !hard_overcurrent_s |=> brake_active ##1 !drive_enable)
    else $error("Direction change did not brake.");
  AST_BRAKE_TO_ALIGN: assert property (@(posedge core_clk) disable iff (sys_rst)
    state_reg == ST_BRAKE && state_next != ST_BRAKE |-> state_next == ST_ALIGN)
    else $error("Brake did not lead to alignment.");
  AST_CARRIER: assert property (@(posedge core_clk) disable iff (sys_rst)
    car_reg != $past(car_reg) |-> $past(car_cnt_reg) == 16'(PWM_HALF_CYCLES - 1)) else $error("Carrier period wrong.");
  AST_HALF_RATE: assert property (@(posedge core_clk) disable iff (sys_rst)
    !sel_mid_s && half_next != half_reg |-> fg_next != fg_reg) else $error("Full rate pulse skipped a toggle.");

endmodule : fmsd_core

// file: verilog/fmsd_pkg.sv
// Shared constants and state type for the fan motor speed and direction block.
package fmsd_pkg;
  // Core clock rate in hertz.
  localparam int unsigned CLK_HZ = 100_000_000;
  // Output stage carrier frequency, typical figure in kilohertz.
  localparam int unsigned PWM_CARRIER_KHZ = 40;
  // Core cycles in one half of the carrier period.
  localparam int unsigned PWM_HALF_CYCLES = CLK_HZ / (PWM_CARRIER_KHZ * 1000 * 2);
  // Lock protection off time in milliseconds at the reference timebase capacitor.
  localparam int unsigned LOCK_OFF_MS = 3000;
  // Timebase frequency in hertz with a 1 nF capacitor.
  localparam int unsigned TB_HZ_1NF = 1000;
  // Reference capacitor for the off time, in picofarads, and the 1 nF point.
  localparam int unsigned LOCK_REF_CAP_PF = 100;
  localparam int unsigned TB_REF_CAP_PF = 1000;
  // Timebase ticks in the lock off interval; the timebase scales inversely with the capacitor.
  localparam int unsigned LOCK_OFF_TICKS = LOCK_OFF_MS * (TB_HZ_1NF * TB_REF_CAP_PF / LOCK_REF_CAP_PF) / 1000;
  // Timebase ticks spent aligning the rotor before the start ramp.
  localparam int unsigned ALIGN_TICKS = 200;
  // Timebase ticks allowed for the first back-EMF edge during start.
  localparam int unsigned START_TIMEOUT_TICKS = 2000;
  // Timebase ticks of braking before the rotor is taken as stopped.
  localparam int unsigned BRAKE_TICKS = 1000;
  // Width of the timebase interval counter.
  localparam int unsigned TICK_W = 16;
  // Width of the commutation period counter.
  localparam int unsigned PER_W = 24;
  // Control states of the motor sequencer.
  typedef enum logic [2:0] {ST_IDLE, ST_ALIGN, ST_START, ST_RUN, ST_BRAKE, ST_LOCK} fmsd_state_t;
endpackage : fmsd_pkg

// file: sim/fmsd_motor_model.sv
// Behavioural fan motor and timebase capacitor oscillator that feed the speed and direction block.
`timescale 1ns/1ps
module fmsd_motor_model
  import fmsd_pkg::*;
#(
  parameter int COMM_CYC = 64,
  parameter int OSC_HALF = 20
)
(
  // Clock, reset and drive state from the block.
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic drive_enable,
  input wire logic brake_active,
  // High keeps back-EMF flat, as a rotor that gives no usable signal.
  input wire logic stall,
  // Motor and capacitor signals toward the block.
  output logic timebase_capacitor,
  output logic zero_cross,
  output logic u_commutate
);
  int osc_cnt = 0; // Cycles in the current oscillator half period.
  int comm_cnt = 0; // Cycles since the last U commutation.
  logic spin_reg = 1'b0; // Rotor turning; it coasts on when drive stops.
  initial timebase_capacitor = 1'b0;
  initial zero_cross = 1'b0;
  initial u_commutate = 1'b0;
  // The oscillator runs free, in reset too, just as the capacitor pin does.
  always @(posedge core_clk)
  begin
    osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
    if (osc_cnt == OSC_HALF - 1)
      timebase_capacitor <= !timebase_capacitor;
  end
  // Commutation runs open loop, so pulses also come while no back-EMF is seen.
  always @(posedge core_clk)
  begin
    spin_reg <= !sys_rst && !brake_active && (spin_reg || drive_enable);
    comm_cnt <= (spin_reg && comm_cnt < COMM_CYC - 1) ? comm_cnt + 1 : 0;
    u_commutate <= spin_reg && comm_cnt == COMM_CYC - 1;
    if (spin_reg && comm_cnt == COMM_CYC - 1 && !stall)
      zero_cross <= !zero_cross;
  end
endmodule : fmsd_motor_model

// file: sim/tb.sv
// Self-checking testbench for the fan motor speed pulse and direction block.
`timescale 1ns/1ps
module tb
  import fmsd_pkg::*;
;
  localparam int COMM = 64; // Core cycles between U commutations.
  localparam int TICK = 40; // Core cycles per timebase tick.
  localparam int LOCK_T = 5; // Shortened lock off interval, in ticks.
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic direction_select = 1'b1; // Starts high, as the pull-up leaves it; t_reverse drives it low.
  logic sel_mid_level = 1'b0;
  logic current_limit_in = 1'b0;
  logic hard_overcurrent = 1'b0;
  logic run_request = 1'b0; // Decoded speed command, driven here as a plain level.
  logic stall = 1'b0;
  logic timebase_capacitor, zero_cross, u_commutate, oe_q, car_q;
  logic drive_enable, brake_active, rotate_reverse, duty_reduce, pwm_carrier, lock_active;
  logic speed_pulse_out_o, speed_pulse_out_oe;
  logic [3:0] mon; // Levels the wait task can poll by index.
  int fail_count = 0;
  int num_checks = 0;
  int tog_cnt = 0; // Speed pulse pin changes since last cleared.
  int car_cnt = 0; // Carrier changes since last cleared.
  int cyc = 0;
  int n;
  assign mon = {duty_reduce, lock_active, brake_active, drive_enable};
  always #5 core_clk = !core_clk;
  fmsd_core #(.LOCK_TICKS(LOCK_T), .ALIGN_T(3), .START_T(10), .BRAKE_T(4)) dut_u (.core_clk(core_clk),
    .sys_rst(sys_rst), .timebase_capacitor(timebase_capacitor), .direction_select(direction_select),
    .sel_mid_level(sel_mid_level), .zero_cross(zero_cross), .current_limit_in(current_limit_in),
    .hard_overcurrent(hard_overcurrent), .run_request(run_request), .u_commutate(u_commutate),
    .drive_enable(drive_enable), .brake_active(brake_active), .rotate_reverse(rotate_reverse),
    .duty_reduce(duty_reduce), .pwm_carrier(pwm_carrier), .lock_active(lock_active),
    .speed_pulse_out_o(speed_pulse_out_o), .speed_pulse_out_oe(speed_pulse_out_oe));
  fmsd_motor_model #(.COMM_CYC(COMM), .OSC_HALF(TICK / 2)) motor_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .drive_enable(drive_enable), .brake_active(brake_active), .stall(stall),
    .timebase_capacitor(timebase_capacitor), .zero_cross(zero_cross), .u_commutate(u_commutate));
  // Edge counters and the hang guard; the whole run needs well under 40000 cycles.
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    oe_q <= speed_pulse_out_oe;
    car_q <= pwm_carrier;
    if (speed_pulse_out_oe !== oe_q)
      tog_cnt <= tog_cnt + 1;
    if (pwm_carrier !== car_q)
      car_cnt <= car_cnt + 1;
    if (cyc == 40000)
    begin
      fail_count = fail_count + 1;
      $display("ERROR %0t run did not finish in time", $time);
      conclude();
    end
  end
  // Level compare; an unknown never passes.
  task automatic chk(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask : chk
  // Count compare against an inclusive range.
  task automatic chk_rng(input int v, input int lo, input int hi, input string what);
    chk(v >= lo && v <= hi, 1'b1, what);
  endtask : chk_rng
  // Waits for monitor bit i to reach v within lim cycles and reports the wait in n.
  task automatic expect_within(input int i, input logic v, input int lim, output int n, input string what);
    n = 0;
    while (mon[i] !== v && n < lim)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(mon[i], v, what);
  endtask : expect_within
  // Counts pin changes over eight commutations, starting right after one.
  task automatic count_win(output int t);
    @(negedge core_clk iff u_commutate);
    tog_cnt = 0;
    repeat (8 * COMM) @(negedge core_clk);
    t = tog_cnt;
  endtask : count_win
  task automatic t_reset();
    chk(drive_enable, 1'b0, "drive after reset");
    chk(speed_pulse_out_oe, 1'b0, "pin not released after reset");
    repeat (50) @(negedge core_clk);
    chk(drive_enable, 1'b0, "drive without run request");
  endtask : t_reset
  // No back-EMF: no pulses, start timeout locks, then a retry after the off time.
  task automatic t_no_bemf();
    @(posedge core_clk);
    stall <= 1'b1;
    run_request <= 1'b1;
    expect_within(0, 1'b1, 6, n, "drive did not start");
    tog_cnt = 0;
    chk(rotate_reverse, 1'b0, "default direction not forward");
    expect_within(2, 1'b1, 16 * TICK, n, "no lock on start timeout");
    chk_rng(n, 12 * TICK, 14 * TICK + 10, "start timeout length");
    chk(tog_cnt == 0, 1'b1, "pulses without back-EMF");
    chk(drive_enable, 1'b0, "output on in lock");
    @(posedge core_clk);
    stall <= 1'b0;
    expect_within(0, 1'b1, (LOCK_T + 2) * TICK, n, "no retry after lock");
    chk_rng(n, (LOCK_T - 1) * TICK, (LOCK_T + 1) * TICK + 10, "lock off time");
    repeat (10 * COMM) @(negedge core_clk);
  endtask : t_no_bemf
  // Pulse placement, rate, half rate, open drain and carrier rate.
  task automatic t_pulse();
    int t;
    logic lvl;
    @(negedge core_clk iff u_commutate);
    // A local copy of the level, so the edge counter's own history is left alone.
    lvl = speed_pulse_out_oe;
    t = 0;
    while (speed_pulse_out_oe === lvl && t < COMM)
    begin
      @(negedge core_clk);
      t++;
    end
    chk_rng(t, COMM / 2, COMM / 2 + 4, "pulse not a quarter turn late");
    count_win(t);
    chk_rng(t, 8, 8, "full rate count");
    chk(speed_pulse_out_o, 1'b0, "pin driven high");
    @(posedge core_clk);
    sel_mid_level <= 1'b1;
    repeat (4 * COMM) @(negedge core_clk);
    count_win(t);
    chk_rng(t, 4, 4, "half rate count");
    @(posedge core_clk);
    sel_mid_level <= 1'b0;
    car_cnt = 0;
    repeat (10000) @(negedge core_clk);
    // A 40 kHz carrier changes level eight times in 10000 core cycles, give or take one at the ends.
    chk_rng(car_cnt, 7, 9, "carrier rate");
  endtask : t_pulse
  // Soft limit trims duty; hard overcurrent locks and later retries.
  task automatic t_current();
    @(posedge core_clk);
    current_limit_in <= 1'b1;
    expect_within(3, 1'b1, 6, n, "no duty reduction");
    @(posedge core_clk);
    current_limit_in <= 1'b0;
    hard_overcurrent <= 1'b1;
    expect_within(2, 1'b1, 6, n, "no lock on overcurrent");
    chk(drive_enable, 1'b0, "output on after overcurrent");
    @(posedge core_clk);
    hard_overcurrent <= 1'b0;
    expect_within(0, 1'b1, (LOCK_T + 2) * TICK, n, "no retry after overcurrent");
    chk_rng(n, (LOCK_T - 1) * TICK, (LOCK_T + 1) * TICK + 10, "overcurrent off time");
    repeat (10 * COMM) @(negedge core_clk);
  endtask : t_current
  // Direction change brakes, realigns reversed, then pulses resume.
  task automatic t_reverse();
    @(posedge core_clk);
    direction_select <= 1'b0;
    expect_within(1, 1'b1, 6, n, "no brake on reversal");
    tog_cnt = 0;
    expect_within(0, 1'b1, 6 * TICK, n, "no restart after brake");
    chk(tog_cnt == 0, 1'b1, "pulses while braking");
    chk(rotate_reverse, 1'b1, "direction not reversed");
    repeat (10 * COMM) @(negedge core_clk);
    chk(tog_cnt > 0, 1'b1, "no pulses after reversal");
  endtask : t_reverse
  // Drive stops while the rotor coasts: pin and carrier freeze.
  task automatic t_stop();
    @(posedge core_clk);
    run_request <= 1'b0;
    expect_within(0, 1'b0, 4, n, "drive did not stop");
    // The counters lag one cycle, so the carrier's legal drop at the stop must be counted before clearing.
    repeat (2) @(negedge core_clk);
    tog_cnt = 0;
    car_cnt = 0;
    repeat (8 * COMM) @(negedge core_clk);
    chk(tog_cnt == 0, 1'b1, "pulses after drive stop");
    chk(car_cnt == 0, 1'b1, "carrier after drive stop");
  endtask : t_stop
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  initial
  begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(negedge core_clk);
    t_reset();
    t_no_bemf();
    t_pulse();
    t_current();
    t_reverse();
    t_stop();
    conclude();
  end
endmodule : tb
